// >>> inc/sensor_port_pkg.sv
// Constants shared by the two-wire slave port and its non-volatile store control.
// Assumes a 250 MHz system clock; the bus oversampling clock is independent.
package sensor_port_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int SYS_CLK_MHZ    = 250;
	localparam int LOAD_TIME_US   = 1500;
	localparam int PROG_TIME_US   = 7000;
	localparam int TIMEOUT_MS     = 35;
	localparam int LOAD_CYCLES    = LOAD_TIME_US * SYS_CLK_MHZ;
	localparam int PROG_CYCLES    = PROG_TIME_US * SYS_CLK_MHZ;
	localparam int TIMEOUT_CYCLES = TIMEOUT_MS * 1000 * SYS_CLK_MHZ;
	localparam int TIMER_W        = 24;

	// ****************************************
	// Register map
	// ****************************************
	localparam int         REG_SLOTS     = 16;
	localparam logic [7:0] REG_TEMP      = 8'h00;
	localparam logic [7:0] REG_CONFIG    = 8'h01;
	localparam logic [7:0] REG_HIGH      = 8'h02;
	localparam logic [7:0] REG_LOW       = 8'h03;
	localparam logic [7:0] REG_UNLOCK    = 8'h04;
	localparam logic [7:0] REG_GP1       = 8'h05;
	localparam logic [7:0] REG_GP2       = 8'h06;
	localparam logic [7:0] REG_OFFSET    = 8'h07;
	localparam logic [7:0] REG_GP3       = 8'h08;
	localparam logic [7:0] REG_ID        = 8'h0F;
	localparam logic [7:0] POINTER_RESET = 8'h00;
	// Slots backed by the store, and slots frozen during the load
	localparam logic [15:0] NV_BACKED    = 16'h01EE;
	localparam logic [15:0] LOAD_LOCKED  = 16'h000E;
	localparam int          UNLOCK_BIT   = 15;
	localparam int          BUSY_BIT     = 14;

	// ****************************************
	// Reset and factory values
	// ****************************************
	localparam logic [15:0] VOL_RESET      = 16'h0000;
	localparam logic [15:0] CONFIG_FACTORY = 16'h0220;
	localparam logic [15:0] HIGH_FACTORY   = 16'h6000;
	localparam logic [15:0] LOW_FACTORY    = 16'h8000;
	localparam logic [15:0] GP_FACTORY     = 16'h0000;
	// Arbitrary identification value
	localparam logic [15:0] DEVICE_ID_DEFAULT = 16'h5A5A;

	// ****************************************
	// Serial addressing
	// ****************************************
	localparam logic [6:0] ADDR_BASE    = 7'h48;
	localparam logic [6:0] GC_ADDR      = 7'h00;
	localparam logic [7:0] GC_RESET_CMD = 8'h06;
	localparam logic [3:0] BYTE_BITS    = 4'h8;

	typedef enum {LS_IDLE, LS_ADDR, LS_ADDR_ACK, LS_PTR, LS_PTR_ACK, LS_WDATA, LS_WDATA_ACK,
		LS_GC_CMD, LS_GC_ACK, LS_TX, LS_TX_ACK} link_state_e;
	typedef enum {NV_LOAD, NV_IDLE, NV_PROG} nv_state_e;

endpackage

// >>> hw/sensor_i2c_slave_nvm_program.sv
// Two-wire slave port with register pointer, volatile registers and store control.
// Assumes bus_clk oversamples the bus well above 400 kHz and pads resolve sda from sda_oe.
`timescale 1ns/1ps

module sensor_i2c_slave_nvm_program #(
	parameter int          LOAD_CYCLES    = sensor_port_pkg::LOAD_CYCLES,
	parameter int          PROG_CYCLES    = sensor_port_pkg::PROG_CYCLES,
	parameter int          TIMEOUT_CYCLES = sensor_port_pkg::TIMEOUT_CYCLES,
	parameter logic [15:0] DEVICE_ID      = sensor_port_pkg::DEVICE_ID_DEFAULT
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        bus_clk,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	input  wire logic [1:0]  address_select_pin,
	input  wire logic [15:0] temp_result,
	output logic             sda_out,
	output logic             sda_oe,
	output logic             nvm_busy,
	output logic [15:0]      config_word,
	output logic [15:0]      high_limit,
	output logic [15:0]      low_limit
);
	import sensor_port_pkg::*;

	// ****************************************
	// Link domain signals
	// ****************************************
	logic        rst_meta;
	logic        bus_rst_n;
	logic        scl_meta, scl_s, scl_d;
	logic        sda_meta, sda_s, sda_d;
	logic [1:0]  strap_meta, strap_s;
	logic        rdack_meta, rdack_s, rdack_d;
	logic        tmo_meta, tmo_s, tmo_d;
	logic        strap_taken;
	logic [6:0]  own_addr;
	link_state_e state;
	logic [3:0]  bit_cnt;
	logic [7:0]  shift;
	logic        is_read;
	logic        is_gc;
	logic        have_high;
	logic [7:0]  high_byte;
	logic [7:0]  register_select_pointer;
	logic [7:0]  wr_ptr;
	logic [15:0] wr_data;
	logic        wr_tgl;
	logic        rd_tgl;
	logic        gc_tgl;
	logic [15:0] tx_word;
	logic [7:0]  tx_byte;
	logic        tx_low;
	logic        master_nack;
	logic        in_frame;
	logic        scl_rise, scl_fall, start_cond, stop_cond, tmo_evt;
	logic        rx_state;

	// ****************************************
	// System domain signals
	// ****************************************
	logic        wr_meta, wr_s, wr_d;
	logic        rd_meta, rd_s, rd_d;
	logic        gc_meta, gc_s, gc_d;
	logic        frame_meta, frame_s;
	logic        scl_meta_sys, scl_sys;
	logic        sda_meta_sys, sda_sys;
	logic        wr_evt, rd_evt, gc_evt;
	nv_state_e   nv_state;
	logic [TIMER_W-1:0] nv_timer;
	logic [TIMER_W-1:0] tmo_cnt;
	logic        tmo_tgl;
	logic        nvm_unlock_bit;
	logic [3:0]  prog_slot;
	logic [15:0] prog_data;
	logic        nvm_we;
	logic [15:0] vol [0:REG_SLOTS-1];
	logic [15:0] nvm [0:REG_SLOTS-1];
	logic [15:0] rd_word;
	logic [15:0] rd_data;
	logic        rd_ack_tgl;
	logic [3:0]  wr_slot;
	logic        wr_mapped;

	// ****************************************
	// Link domain synchronisers
	// ****************************************
	always_ff @(posedge bus_clk) begin
		rst_meta  <= rst_n;
		bus_rst_n <= rst_meta;
	end

	// Oversampled pins follow any bus rate up to 400 kHz
	always_ff @(posedge bus_clk) begin
		if (!bus_rst_n) begin
			{scl_meta, scl_s, scl_d} <= 3'b111;
			{sda_meta, sda_s, sda_d} <= 3'b111;
			{rdack_meta, rdack_s, rdack_d} <= 3'b000;
			{tmo_meta, tmo_s, tmo_d} <= 3'b000;
		end else begin
			{scl_meta, scl_s, scl_d} <= {scl_in, scl_meta, scl_s};
			{sda_meta, sda_s, sda_d} <= {sda_in, sda_meta, sda_s};
			{rdack_meta, rdack_s, rdack_d} <= {rd_ack_tgl, rdack_meta, rdack_s};
			{tmo_meta, tmo_s, tmo_d} <= {tmo_tgl, tmo_meta, tmo_s};
		end
	end

	// Strap kept out of reset so it has settled when it is caught
	always_ff @(posedge bus_clk) begin
		strap_meta <= address_select_pin;
		strap_s    <= strap_meta;
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	// Edges of data while clock high
	assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
	assign tmo_evt    = tmo_s ^ tmo_d;
	assign rx_state   = (state == LS_ADDR) || (state == LS_PTR) || (state == LS_WDATA) || (state == LS_GC_CMD);

	always_ff @(posedge bus_clk) begin
		if (!bus_rst_n) begin
			strap_taken <= 1'b0;
			own_addr    <= ADDR_BASE;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			own_addr    <= {ADDR_BASE[6:2], strap_s};
		end
	end

	// Read word arrives well before the ack clock ends
	always_ff @(posedge bus_clk) begin
		if (!bus_rst_n) begin
			tx_word <= VOL_RESET;
		end else if (rdack_s ^ rdack_d) begin
			tx_word <= rd_data;
		end
	end

	always_ff @(posedge bus_clk) begin
		if (!bus_rst_n) begin
			in_frame <= 1'b0;
			sda_out  <= 1'b0;
		end else begin
			in_frame <= (state != LS_IDLE);
			sda_out  <= 1'b0;
		end
	end

	// ****************************************
	// Serial engine
	// ****************************************
	// Only the data line has an enable; the clock is input only
	always_ff @(posedge bus_clk) begin
		if (!bus_rst_n) begin
			state       <= LS_IDLE;
			bit_cnt     <= 4'h0;
			shift       <= 8'h00;
			is_read     <= 1'b0;
			is_gc       <= 1'b0;
			have_high   <= 1'b0;
			high_byte   <= 8'h00;
			register_select_pointer <= POINTER_RESET;
			wr_ptr      <= POINTER_RESET;
			wr_data     <= VOL_RESET;
			wr_tgl      <= 1'b0;
			rd_tgl      <= 1'b0;
			gc_tgl      <= 1'b0;
			tx_byte     <= 8'h00;
			tx_low      <= 1'b0;
			master_nack <= 1'b0;
			sda_oe      <= 1'b0;
		// Stop or timeout frees the line
		end else if (stop_cond || tmo_evt) begin
			state  <= LS_IDLE;
			sda_oe <= 1'b0;
		end else if (start_cond) begin
			state   <= LS_ADDR;
			bit_cnt <= 4'h0;
			is_gc   <= 1'b0;
			sda_oe  <= 1'b0;
		end else if (scl_rise) begin
			if (rx_state) begin
				shift   <= {shift[6:0], sda_s};
				bit_cnt <= bit_cnt + 4'h1;
			end
			if (state == LS_TX_ACK) begin
				master_nack <= sda_s;
			end
		end else if (scl_fall) begin
			unique case (state)
				LS_IDLE: begin
				end
				LS_ADDR: begin
					if (bit_cnt == BYTE_BITS) begin
						// Ack own address on ninth clock
						if (shift[7:1] == own_addr) begin
							sda_oe  <= 1'b1;
							is_read <= shift[0];
							state   <= LS_ADDR_ACK;
							if (shift[0]) begin
								rd_tgl <= ~rd_tgl;
							end
						end else if (shift[7:1] == GC_ADDR && !shift[0]) begin
							sda_oe  <= 1'b1;
							is_read <= 1'b0;
							is_gc   <= 1'b1;
							state   <= LS_ADDR_ACK;
						end else begin
							state <= LS_IDLE;
						end
					end
				end
				LS_ADDR_ACK: begin
					bit_cnt <= 4'h0;
					if (is_gc) begin
						sda_oe <= 1'b0;
						state  <= LS_GC_CMD;
					end else if (is_read) begin
						sda_oe  <= ~tx_word[15];
						tx_byte <= {tx_word[14:8], 1'b0};
						tx_low  <= 1'b1;
						bit_cnt <= 4'h1;
						state   <= LS_TX;
					end else begin
						sda_oe <= 1'b0;
						state  <= LS_PTR;
					end
				end
				LS_PTR: begin
					if (bit_cnt == BYTE_BITS) begin
						register_select_pointer <= shift;
						sda_oe <= 1'b1;
						state  <= LS_PTR_ACK;
					end
				end
				// Frame may end here with only the pointer
				LS_PTR_ACK, LS_WDATA_ACK: begin
					sda_oe  <= 1'b0;
					bit_cnt <= 4'h0;
					if (state == LS_PTR_ACK) begin
						have_high <= 1'b0;
					end
					state <= LS_WDATA;
				end
				LS_WDATA: begin
					if (bit_cnt == BYTE_BITS) begin
						// Each data byte acked, words written
						sda_oe <= 1'b1;
						state  <= LS_WDATA_ACK;
						if (!have_high) begin
							high_byte <= shift;
							have_high <= 1'b1;
						end else begin
							wr_data   <= {high_byte, shift};
							wr_ptr    <= register_select_pointer;
							wr_tgl    <= ~wr_tgl;
							have_high <= 1'b0;
						end
					end
				end
				LS_GC_CMD: begin
					if (bit_cnt == BYTE_BITS) begin
						// Reset command acked and passed on
						if (shift == GC_RESET_CMD) begin
							sda_oe <= 1'b1;
							gc_tgl <= ~gc_tgl;
							register_select_pointer <= POINTER_RESET;
							state  <= LS_GC_ACK;
						end else begin
							state <= LS_IDLE;
						end
					end
				end
				LS_GC_ACK: begin
					sda_oe <= 1'b0;
					state  <= LS_IDLE;
				end
				LS_TX: begin
					if (bit_cnt == BYTE_BITS) begin
						sda_oe <= 1'b0;
						state  <= LS_TX_ACK;
					end else begin
						sda_oe  <= ~tx_byte[7];
						tx_byte <= {tx_byte[6:0], 1'b0};
						bit_cnt <= bit_cnt + 4'h1;
					end
				end
				LS_TX_ACK: begin
					if (master_nack) begin
						state <= LS_IDLE;
					end else begin
						sda_oe  <= tx_low ? ~tx_word[7] : ~tx_word[15];
						tx_byte <= tx_low ? {tx_word[6:0], 1'b0} : {tx_word[14:8], 1'b0};
						tx_low  <= ~tx_low;
						bit_cnt <= 4'h1;
						state   <= LS_TX;
					end
				end
			endcase
		end
	end

	// ****************************************
	// System domain synchronisers
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			{wr_meta, wr_s, wr_d} <= 3'b000;
			{rd_meta, rd_s, rd_d} <= 3'b000;
			{gc_meta, gc_s, gc_d} <= 3'b000;
			{frame_meta, frame_s} <= 2'b00;
			{scl_meta_sys, scl_sys} <= 2'b11;
			{sda_meta_sys, sda_sys} <= 2'b11;
		end else begin
			{wr_meta, wr_s, wr_d} <= {wr_tgl, wr_meta, wr_s};
			{rd_meta, rd_s, rd_d} <= {rd_tgl, rd_meta, rd_s};
			{gc_meta, gc_s, gc_d} <= {gc_tgl, gc_meta, gc_s};
			{frame_meta, frame_s} <= {in_frame, frame_meta};
			{scl_meta_sys, scl_sys} <= {scl_in, scl_meta_sys};
			{sda_meta_sys, sda_sys} <= {sda_in, sda_meta_sys};
		end
	end

	assign wr_evt    = wr_s ^ wr_d;
	assign rd_evt    = rd_s ^ rd_d;
	assign gc_evt    = gc_s ^ gc_d;
	assign wr_slot   = wr_ptr[3:0];
	assign wr_mapped = (wr_ptr[7:4] == 4'h0);
	assign nvm_we    = (nv_state == NV_PROG) && (nv_timer == TIMER_W'(PROG_CYCLES - 1));

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tmo_cnt <= '0;
			tmo_tgl <= 1'b0;
		end else if (frame_s && (!scl_sys || !sda_sys)) begin
			if (tmo_cnt == TIMER_W'(TIMEOUT_CYCLES - 1)) begin
				tmo_cnt <= '0;
				tmo_tgl <= ~tmo_tgl;
			end else begin
				tmo_cnt <= tmo_cnt + 1'b1;
			end
		end else begin
			tmo_cnt <= '0;
		end
	end

	// ****************************************
	// Read responder
	// ****************************************
	// Word chosen by the held pointer
	always_comb begin
		rd_word = VOL_RESET;
		if (register_select_pointer == REG_TEMP) begin
			rd_word = temp_result;
		end else if (register_select_pointer == REG_UNLOCK) begin
			rd_word[UNLOCK_BIT] = nvm_unlock_bit;
			rd_word[BUSY_BIT]   = (nv_state != NV_IDLE);
		end else if (register_select_pointer == REG_ID) begin
			rd_word = DEVICE_ID;
		end else if (register_select_pointer[7:4] == 4'h0) begin
			rd_word = vol[register_select_pointer[3:0]];
		end
	end

	// Reads answered in every store state
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rd_data    <= VOL_RESET;
			rd_ack_tgl <= 1'b0;
		end else if (rd_evt) begin
			rd_data    <= rd_word;
			rd_ack_tgl <= ~rd_ack_tgl;
		end
	end

	// ****************************************
	// Store control and volatile registers
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			nv_state       <= NV_LOAD;
			nv_timer       <= '0;
			nvm_unlock_bit <= 1'b0;
			prog_slot      <= 4'h0;
			prog_data      <= VOL_RESET;
			for (int i = 0; i < REG_SLOTS; i++) begin
				vol[i] <= VOL_RESET;
			end
		end else if (gc_evt) begin
			nv_state       <= NV_LOAD;
			nv_timer       <= '0;
			nvm_unlock_bit <= 1'b0;
		end else begin
			unique case (nv_state)
				NV_LOAD: begin
					// Copy at the end of the load time
					if (nv_timer == TIMER_W'(LOAD_CYCLES - 1)) begin
						nv_timer <= '0;
						nv_state <= NV_IDLE;
						for (int i = 0; i < REG_SLOTS; i++) begin
							if (NV_BACKED[i]) begin
								vol[i] <= nvm[i];
							end
						end
					end else begin
						nv_timer <= nv_timer + 1'b1;
						if (wr_evt && wr_mapped && NV_BACKED[wr_slot] && !LOAD_LOCKED[wr_slot]) begin
							vol[wr_slot] <= wr_data;
						end
					end
				end
				NV_IDLE: begin
					if (wr_evt && wr_ptr == REG_UNLOCK) begin
						nvm_unlock_bit <= wr_data[UNLOCK_BIT];
					end else if (wr_evt && wr_mapped && NV_BACKED[wr_slot]) begin
						vol[wr_slot] <= wr_data;
						if (nvm_unlock_bit) begin
							prog_slot <= wr_slot;
							prog_data <= wr_data;
							nv_timer  <= '0;
							nv_state  <= NV_PROG;
						end
					end
				end
				NV_PROG: begin
					if (nvm_we) begin
						nv_timer <= '0;
						nv_state <= NV_IDLE;
					end else begin
						nv_timer <= nv_timer + 1'b1;
					end
				end
			endcase
		end
	end

	// Store keeps its contents across every reset
	initial begin
		for (int i = 0; i < REG_SLOTS; i++) begin
			nvm[i] = GP_FACTORY;
		end
		nvm[REG_CONFIG[3:0]] = CONFIG_FACTORY;
		nvm[REG_HIGH[3:0]]   = HIGH_FACTORY;
		nvm[REG_LOW[3:0]]    = LOW_FACTORY;
	end

	always @(posedge sys_clk) begin
		if (nvm_we) begin
			nvm[prog_slot] <= prog_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			nvm_busy    <= 1'b1;
			config_word <= VOL_RESET;
			high_limit  <= VOL_RESET;
			low_limit   <= VOL_RESET;
		end else begin
			nvm_busy    <= (nv_state != NV_IDLE);
			config_word <= vol[REG_CONFIG[3:0]];
			high_limit  <= vol[REG_HIGH[3:0]];
			low_limit   <= vol[REG_LOW[3:0]];
		end
	end

endmodule

// >>> sim/sensor_port_asserts.sv
// Port-level checker for the two-wire slave port and store control.
// Assumes the bind hands on the shortened load, programming and timeout counts.
`timescale 1ns/1ps
module sensor_port_asserts #(
	parameter int LOAD_CYCLES    = 20,
	parameter int PROG_CYCLES    = 20,
	parameter int TIMEOUT_CYCLES = 200
) (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        bus_clk,
	input wire logic        scl_in,
	input wire logic        sda_in,
	input wire logic [1:0]  address_select_pin,
	input wire logic [15:0] temp_result,
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic        nvm_busy,
	input wire logic [15:0] config_word,
	input wire logic [15:0] high_limit,
	input wire logic [15:0] low_limit
);
	int load_cnt;
	int busy_len;
	int low_cnt;

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			load_cnt <= 0;
		else if (load_cnt < LOAD_CYCLES + 5)
			load_cnt <= load_cnt + 1;
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !nvm_busy)
			busy_len <= 0;
		else
			busy_len <= busy_len + 1;
	end
	// Saturates so the timeout check fires on every cycle of a clock-low hang past the limit
	always_ff @(posedge sys_clk) begin
		if (!rst_n || scl_in)
			low_cnt <= 0;
		else if (low_cnt < TIMEOUT_CYCLES + 20)
			low_cnt <= low_cnt + 1;
	end

	a_busy_at_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(rst_n) |-> nvm_busy) else $error("busy low at reset release");
	a_load_keeps_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
		load_cnt < LOAD_CYCLES |-> nvm_busy) else $error("busy dropped during load");
	a_load_ends: assert property (@(posedge sys_clk) disable iff (!rst_n)
		load_cnt == LOAD_CYCLES + 4 |-> !nvm_busy) else $error("load did not end");
	a_prog_min_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(nvm_busy) |-> busy_len >= PROG_CYCLES - 2) else $error("busy too short");
	a_timeout_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
		low_cnt == TIMEOUT_CYCLES + 20 |-> !sda_oe) else $error("data line held past timeout");
	a_open_drain: assert property (@(posedge bus_clk) disable iff (!rst_n)
		sda_oe |-> sda_out == 1'b0) else $error("data line driven high");
	a_oe_scl_low: assert property (@(posedge bus_clk) disable iff (!rst_n)
		$changed(sda_oe) |-> !scl_in) else $error("data changed with clock high");
	a_ack_holds: assert property (@(posedge bus_clk) disable iff (!rst_n)
		sda_oe && scl_in |=> sda_oe) else $error("data released during clock high");
endmodule

bind sensor_i2c_slave_nvm_program sensor_port_asserts #(.LOAD_CYCLES(LOAD_CYCLES), .PROG_CYCLES(PROG_CYCLES),
	.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .bus_clk(bus_clk),
	.scl_in(scl_in), .sda_in(sda_in), .address_select_pin(address_select_pin), .temp_result(temp_result),
	.sda_out(sda_out), .sda_oe(sda_oe), .nvm_busy(nvm_busy), .config_word(config_word),
	.high_limit(high_limit), .low_limit(low_limit));

// >>> sim/i2c_host_model.sv
// Bus master model driving the clock wire and its share of the data wire.
// Assumes the bench resolves the data wire from a pull-up and the slave enable.
`timescale 1ns/1ps
module i2c_host_model #(
	parameter int QUARTER = 8
) (
	input  wire logic sys_clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda
);
	// Clock stands high outside frames
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic q();
		repeat (QUARTER) @(negedge sys_clk);
	endtask
	task automatic start();
		sda = 1'b1;
		q();
		scl = 1'b1;
		q();
		sda = 1'b0;
		q();
		scl = 1'b0;
		q();
	endtask
	task automatic stop();
		sda = 1'b0;
		q();
		scl = 1'b1;
		q();
		sda = 1'b1;
		q();
	endtask
	task automatic bitx(input logic b, output logic r);
		sda = b;
		q();
		scl = 1'b1;
		q();
		r = sda_line;
		q();
		scl = 1'b0;
		q();
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, d[i]);
		bitx(last, r);
	endtask
	// Clocks a byte with no start in front of it
	task automatic noframe_byte(input logic [7:0] d, output logic ack);
		scl = 1'b0;
		q();
		wbyte(d, ack);
		scl = 1'b1;
		q();
	endtask
endmodule

// >>> sim/sensor_i2c_slave_nvm_program_tb.sv
// Self-checking bench for the two-wire slave port and store control.
// Assumes a host model on the wires and shortened load, programming and timeout counts.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module sensor_i2c_slave_nvm_program_tb;
	import sensor_port_pkg::*;
	localparam int LOAD = 5000;
	localparam int PROG = 3000;
	// Must outlast the longest legal low run on either wire, a zero word
	localparam int TOUT = 1000;
	logic        sys_clk = 1'b0;
	logic        bus_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [1:0]  strap = 2'b00;
	logic [15:0] temp_result = 16'h0000;
	logic        scl;
	logic        sda;
	logic        sda_line;
	logic        sda_out;
	logic        sda_oe;
	logic        nvm_busy;
	logic [15:0] config_word;
	logic [15:0] high_limit;
	logic [15:0] low_limit;
	logic [6:0]  dev;
	logic        ack;
	logic [15:0] v;
	logic [15:0] d;
	int          n_mismatch = 0;
	int          checks_done = 0;
	int          cyc = 0;

	// Pull-up on the data wire
	assign sda_line = sda & ~sda_oe;
	always #2 sys_clk = ~sys_clk;
	initial begin
		#1.3;
		forever #3 bus_clk = ~bus_clk;
	end

	sensor_i2c_slave_nvm_program #(.LOAD_CYCLES(LOAD), .PROG_CYCLES(PROG), .TIMEOUT_CYCLES(TOUT)) uut (
		.sys_clk(sys_clk), .rst_n(rst_n), .bus_clk(bus_clk), .scl_in(scl), .sda_in(sda_line),
		.address_select_pin(strap), .temp_result(temp_result), .sda_out(sda_out), .sda_oe(sda_oe),
		.nvm_busy(nvm_busy), .config_word(config_word), .high_limit(high_limit), .low_limit(low_limit));
	i2c_host_model m (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda(sda));

	task automatic summarize();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 90000) begin
			n_mismatch++;
			summarize();
		end
	end

	function automatic logic [6:0] addr_of(input logic [1:0] s);
		return {5'b10010, s};
	endfunction
	task automatic do_reset(input logic [1:0] s);
		strap = s;
		rst_n = 1'b0;
		repeat (8) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (12) @(negedge sys_clk);
		dev = addr_of(s);
	endtask
	task automatic put(input logic [7:0] b);
		logic a;
		m.wbyte(b, a);
		`CHK(a, 1'b1)
	endtask
	task automatic rd_cur(output logic [15:0] w);
		m.start();
		put({dev, 1'b1});
		m.rbyte(1'b0, w[15:8]);
		m.rbyte(1'b1, w[7:0]);
		m.stop();
	endtask
	task automatic rd_reg(input logic [7:0] p, output logic [15:0] w);
		m.start();
		put({dev, 1'b0});
		put(p);
		rd_cur(w);
	endtask
	task automatic wr_reg(input logic [7:0] p, input logic [15:0] w);
		m.start();
		put({dev, 1'b0});
		put(p);
		put(w[15:8]);
		put(w[7:0]);
		m.stop();
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 20000 && nvm_busy !== 1'b0; i++)
			@(negedge sys_clk);
		`CHK(nvm_busy, 1'b0)
	endtask
	task automatic gcall();
		m.start();
		put({GC_ADDR, 1'b0});
		put(GC_RESET_CMD);
		m.stop();
		repeat (8) @(negedge sys_clk);
		wait_idle();
	endtask

	initial begin
		void'($urandom(88639));
		for (int s = 0; s < 4; s++) begin
			do_reset(2'(s));
			m.start();
			m.wbyte({addr_of(2'(s) ^ 2'b01), 1'b0}, ack);
			`CHK(ack, 1'b0)
			m.stop();
			m.start();
			put({dev, 1'b0});
			put(REG_ID);
			m.stop();
			rd_cur(v);
			`CHK(v, DEVICE_ID_DEFAULT)
		end
		do_reset(2'b10);
		d = 16'($urandom);
		temp_result = d;
		rd_cur(v);
		`CHK(v, d)
		d = 16'($urandom);
		wr_reg(REG_CONFIG, d);
		rd_reg(REG_UNLOCK, v);
		`CHK(v, 16'h4000)
		`CHK(config_word, VOL_RESET)
		wait_idle();
		`CHK(config_word, CONFIG_FACTORY)
		`CHK(high_limit, HIGH_FACTORY)
		`CHK(low_limit, LOW_FACTORY)
		d = 16'($urandom);
		wr_reg(REG_HIGH, d);
		repeat (8) @(negedge sys_clk);
		`CHK(high_limit, d)
		`CHK(nvm_busy, 1'b0)
		rd_reg(REG_HIGH, v);
		`CHK(v, d)
		rd_cur(v);
		`CHK(v, d)
		gcall();
		`CHK(high_limit, HIGH_FACTORY)
		// low limit written while unlocked is programmed into the store
		wr_reg(REG_UNLOCK, 16'h8000);
		d = 16'($urandom);
		wr_reg(REG_LOW, d);
		repeat (8) @(negedge sys_clk);
		`CHK(nvm_busy, 1'b1)
		rd_reg(REG_UNLOCK, v);
		`CHK(v, 16'hC000)
		wait_idle();
		gcall();
		`CHK(low_limit, d)
		rd_reg(REG_UNLOCK, v);
		`CHK(v, 16'h0000)
		m.start();
		put({dev, 1'b1});
		repeat (2) @(negedge sys_clk);
		`CHK(sda_oe, 1'b1)
		repeat (TOUT + 100) @(negedge sys_clk);
		`CHK(sda_oe, 1'b0)
		m.stop();
		m.noframe_byte({dev, 1'b1}, ack);
		`CHK(ack, 1'b0)
		rd_cur(v);
		`CHK(v, 16'h0000)
		summarize();
	end
endmodule
